// ==== dv/asfb_top_test.sv ====
// Self-checking bench of the auxiliary flag bank
`timescale 1ns/1ns
`default_nettype none
module asfb_top_test
    import asfb_pkg::*;
;
    logic clock = 1'b0;
    logic nrst, cyc, stb, we, pwr;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
    logic [4:0] slots;
    wire logic [31:0] dat_o;
    wire logic [7:0] code, restarts;
    wire logic ack, c_err, c_mnt, c_busy, rst_o, done, fail, rdy, scan, irq;
    int bad_count, checks, cycles;
    asfb_word_t q;
    asfb_top #(.SCAN_CYCLES(40), .TICK_CYCLES(4), .HOLD_WORDS(32)) i_asfb_top (
        .clock(clock), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .comm_err(c_err),
        .comm_mounted(c_mnt), .comm_busy(c_busy), .comm_restart(rst_o),
        .net_done(done), .net_fail(fail), .net_code(code), .net_ready(rdy),
        .s1_hw_fault(slots[4]), .s1_serial_fault(slots[3]),
        .s2_hw_fault(slots[2]), .s2_setup_fault(slots[1]),
        .s2_stop_fault(slots[0]), .pwr_restored(pwr),
        .scan_pulse(scan), .irq(irq));
    asfb_unit_model i_asfb_unit_model (
        .clock(clock), .comm_restart(rst_o), .comm_err(c_err),
        .comm_mounted(c_mnt), .comm_busy(c_busy), .net_done(done),
        .net_fail(fail), .net_code(code), .net_ready(rdy),
        .restarts(restarts));
    always #10 clock = ~clock;
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Ceiling well above the thousand or so cycles the run needs
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            $display("[ERR] %0t timeout", $time);
            print_verdict();
        end
    end
    task automatic chk16(input asfb_word_t g, input asfb_word_t e);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %0t word got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e, input string w);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %0t %s got %b", $time, w, g);
        end
    endtask
    task automatic wb(input logic w, input logic [5:0] i, input asfb_word_t d,
                      input logic [3:0] s);
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {i, 2'b00};
        sel <= s;
        dat <= {16'h0000, d};
        // No local limit: only the bench timeout ends a wait for ack
        do begin
            @(posedge clock);
        end while (ack !== 1'b1);
        chk1(ack, 1'b1, "ack");
        q = dat_o[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] i, input asfb_word_t d);
        wb(1'b1, i, d, 4'h3);
    endtask
    task automatic rdc(input logic [5:0] i, input asfb_word_t e);
        wb(1'b0, i, 16'h0000, 4'h3);
        chk16(q, e);
    endtask
    task automatic wait_scan();
        int n;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (scan !== 1'b1 && n < 200);
        chk1(scan, 1'b1, "scan");
    endtask
    task automatic irq_is(input logic e);
        @(negedge clock);
        chk1(irq, e, "irq");
    endtask
    task automatic do_reset();
        nrst <= 1'b0;
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
    endtask
    task automatic t_flags();
        wait_scan();
        i_asfb_unit_model.set_link(1'b1, 1'b1, 1'b0);
        i_asfb_unit_model.fault();
        rdc(6'h00, 16'h0000);
        wait_scan();
        rdc(6'h00, 16'h0800);
        rdc(6'h02, 16'h8200);
        i_asfb_unit_model.set_link(1'b1, 1'b0, 1'b0);
        wait_scan();
        rdc(6'h02, 16'h8000);
    endtask
    task automatic t_net();
        i_asfb_unit_model.net_op(8'h5A, 1'b1);
        wait_scan();
        rdc(6'h02, 16'h815A);
        i_asfb_unit_model.net_op(8'hC3, 1'b0);
        wait_scan();
        rdc(6'h02, 16'h80C3);
    endtask
    task automatic t_service();
        // 40 busy cycles at 4 per tick is ten units: BCD shows 0010
        i_asfb_unit_model.set_link(1'b1, 1'b0, 1'b1);
        wait_scan();
        wait_scan();
        rdc(6'h03, 16'h0010);
        i_asfb_unit_model.set_link(1'b1, 1'b0, 1'b0);
        wait_scan();
        wait_scan();
        rdc(6'h03, 16'h0000);
    endtask
    task automatic t_restart();
        wr(6'h00, 16'hFFFF);
        rdc(6'h00, 16'h0800);
        wr(6'h01, 16'hFFFF);
        rdc(6'h01, 16'h0800);
        chk16({8'h00, restarts}, 16'h0000);
        wr(6'h01, 16'h0000);
        repeat (3) @(posedge clock);
        chk16({8'h00, restarts}, 16'h0001);
        wait_scan();
        rdc(6'h00, 16'h0000);
        wr(6'h10, 16'hFFFF);
        rdc(6'h10, 16'h0000);
    endtask
    task automatic t_irq();
        rdc(6'h08, 16'h0007);
        wr(6'h09, 16'h0002);
        wr(6'h0A, 16'h001F);
        rdc(6'h08, 16'h0000);
        irq_is(1'b0);
        i_asfb_unit_model.net_op(8'h11, 1'b1);
        wait_scan();
        rdc(6'h08, 16'h0002);
        irq_is(1'b1);
        wr(6'h09, 16'h0000);
        irq_is(1'b0);
        wr(6'h09, 16'h0002);
        irq_is(1'b1);
        wr(6'h0A, 16'h0002);
        irq_is(1'b0);
        rdc(6'h08, 16'h0000);
    endtask
    task automatic t_slots();
        logic [4:0] v[8] = '{5'h10, 5'h08, 5'h18, 5'h04, 5'h02, 5'h01,
                              5'h03, 5'h00};
        asfb_word_t e[8] = '{16'h0001, 16'h0004, 16'h0001, 16'h0100,
                             16'h0300, 16'h0400, 16'h0300, 16'h0000};
        for (int k = 0; k < 8; k++) begin
            @(posedge clock);
            slots <= v[k];
            wait_scan();
            rdc(6'h04, e[k]);
        end
    endtask
    task automatic t_power_hold();
        repeat (3) begin
            @(posedge clock);
            pwr <= 1'b1;
            @(posedge clock);
            pwr <= 1'b0;
        end
        rdc(6'h08, 16'h0018);
        rdc(6'h17, 16'h0003);
        wait_scan();
        rdc(6'h17, 16'h0003);
        wr(6'h20, 16'hA5C3);
        wr(6'h21, 16'hFFFF);
        wb(1'b1, 6'h21, 16'h1234, 4'h1);
        do_reset();
        rdc(6'h20, 16'hA5C3);
        rdc(6'h21, 16'hFF34);
    endtask
    initial begin
        nrst = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'h0;
        dat = 32'h0000_0000;
        slots = 5'h00;
        pwr = 1'b0;
        do_reset();
        t_flags();
        t_net();
        t_service();
        t_restart();
        t_irq();
        t_slots();
        t_power_hold();
        print_verdict();
    end
endmodule
`default_nettype wire

// ==== dv/asfb_unit_model.sv ====
// Behavioural communications unit facing the flag bank
`timescale 1ns/1ns
`default_nettype none
module asfb_unit_model (
    input wire logic clock,
    input wire logic comm_restart,
    output logic comm_err,
    output logic comm_mounted,
    output logic comm_busy,
    output logic net_done,
    output logic net_fail,
    output logic [7:0] net_code,
    output logic net_ready,
    output logic [7:0] restarts
);
    initial begin
        comm_err = 1'b0;
        comm_mounted = 1'b0;
        comm_busy = 1'b0;
        net_done = 1'b0;
        net_fail = 1'b1;
        net_code = 8'hFF;
        net_ready = 1'b0;
        restarts = 8'h00;
    end
    // A restart clears the unit's own error, as a real unit would
    always @(posedge clock) begin
        if (comm_restart === 1'b1) begin
            restarts <= restarts + 8'h01;
            comm_err <= 1'b0;
        end
    end
    task automatic set_link(input logic m, input logic r, input logic b);
        @(posedge clock);
        comm_mounted <= m;
        net_ready <= r;
        comm_busy <= b;
    endtask
    task automatic fault();
        @(posedge clock);
        comm_err <= 1'b1;
    endtask
    task automatic net_op(input logic [7:0] code, input logic fail);
        @(posedge clock);
        net_done <= 1'b1;
        net_code <= code;
        net_fail <= fail;
        @(posedge clock);
        net_done <= 1'b0;
        // Junk outside the pulse so nothing leans on stale fields
        net_code <= ~code;
        net_fail <= ~fail;
    endtask
endmodule
`default_nettype wire

// ==== hdl/asfb_hold_mem.sv ====
// Retentive holding word memory with byte-lane writes
`timescale 1ns/1ns
`default_nettype none
`include "asfb_map.svh"
module asfb_hold_mem
    import asfb_pkg::*;
#(
    parameter int WORDS = 32,
    parameter int AW = $clog2(WORDS)
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic we,
    input wire logic [1:0] be,
    input wire logic [AW-1:0] addr,
    input wire asfb_word_t wdata,
    output asfb_word_t rdata
);
    // No reset on the array: contents must outlive reset and run/stop
    logic [7:0] lane_mem [2][WORDS];
    asfb_word_t rdata_ff;

    for (genvar l = 0; l < 2; l++) begin : g_lane
        always_ff @(posedge clock) begin
            if (we && be[l]) begin
                lane_mem[l][addr] <= wdata[l*8 +: 8];
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdata_ff <= `ASFB_RST_WORD;
        end else begin
            rdata_ff <= {lane_mem[1][addr], lane_mem[0][addr]};
        end
    end

    assign rdata = rdata_ff;
endmodule
`default_nettype wire

// ==== hdl/asfb_top.sv ====
// Auxiliary status flag bank: scan refresh, Wishbone slave, interrupts
`timescale 1ns/1ns
`default_nettype none
`include "asfb_map.svh"
module asfb_top
    import asfb_pkg::*;
#(
    parameter int SCAN_CYCLES = `ASFB_SCAN_NS / `ASFB_CLK_NS,
    parameter int TICK_CYCLES = `ASFB_TICK_NS / `ASFB_CLK_NS,
    parameter int HOLD_WORDS = 32
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic comm_err,
    input wire logic comm_mounted,
    input wire logic comm_busy,
    output logic comm_restart,
    input wire logic net_done,
    input wire logic net_fail,
    input wire logic [7:0] net_code,
    input wire logic net_ready,
    input wire logic s1_hw_fault,
    input wire logic s1_serial_fault,
    input wire logic s2_hw_fault,
    input wire logic s2_setup_fault,
    input wire logic s2_stop_fault,
    input wire logic pwr_restored,
    output logic scan_pulse,
    output logic irq
);
    localparam int HAW = $clog2(HOLD_WORDS);

    // Bus decode
    asfb_bus_t bus_ff;
    asfb_bus_t nxt_bus;
    wire logic [5:0] idx = wb_adr_i[7:2];
    wire logic req = wb_cyc_i & wb_stb_i;
    wire logic take = req & (bus_ff == ASFB_BUS_IDLE);
    wire logic wr_go = req & wb_we_i & (bus_ff == ASFB_BUS_ACK);
    wire logic [5:0] hold_off = idx - `ASFB_IDX_HOLD;
    wire logic hold_hit = (idx >= `ASFB_IDX_HOLD) &&
                          (32'(hold_off) < 32'(HOLD_WORDS));
    wire asfb_word_t wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire asfb_word_t wdat = wb_dat_i[15:0] & wmask;
    wire logic wr_rst = wr_go & (idx == `ASFB_IDX_RST) & wb_sel_i[1];
    wire logic wr_ien = wr_go & (idx == `ASFB_IDX_IEN) & wb_sel_i[0];
    wire logic wr_icl = wr_go & (idx == `ASFB_IDX_ICL) & wb_sel_i[0];

    // Scan divider
    logic [31:0] scan_cnt_ff;
    wire logic scan_en = scan_cnt_ff == 32'(SCAN_CYCLES - 1);

    // Flag state
    logic err_bit_ff;
    logic restart_bit_ff;
    logic restart_pulse_ff;
    logic [7:0] pend_code_ff;
    logic pend_err_ff;
    logic [7:0] net_code_ff;
    logic net_err_ff;
    logic net_en_ff;
    logic conn_ff;
    asfb_word_t srv_word_ff;
    asfb_word_t srv_acc_ff;
    asfb_word_t nxt_srv_acc;
    logic [31:0] tick_cnt_ff;
    asfb_word_t ibd_ff;
    asfb_word_t pwr_cnt_ff;
    logic [`ASFB_IRQ_W-1:0] ist_ff;
    logic [`ASFB_IRQ_W-1:0] ien_ff;
    asfb_word_t rd_ff;
    logic hold_sel_ff;
    asfb_word_t hold_q;

    // Completion of an instruction in the refresh cycle is not lost
    wire logic [7:0] code_src = net_done ? net_code : pend_code_ff;
    wire logic err_src = net_done ? net_fail : pend_err_ff;

    // Slot codes; hardware fault outranks the others
    wire logic [7:0] s1_code = s1_hw_fault ? `ASFB_CODE_HW :
                               s1_serial_fault ? `ASFB_CODE_SERIAL :
                               `ASFB_CODE_OK;
    wire logic [7:0] s2_code = s2_hw_fault ? `ASFB_CODE_HW :
                               s2_setup_fault ? `ASFB_CODE_SETUP :
                               s2_stop_fault ? `ASFB_CODE_STOP :
                               `ASFB_CODE_OK;
    wire asfb_word_t ibd_src = {s2_code, s1_code};

    // Servicing time accumulator, one BCD digit per loop pass
    wire logic tick = comm_busy & (tick_cnt_ff == 32'(TICK_CYCLES - 1));
    logic [4:0] carry;
    asfb_word_t bcd_inc;
    assign carry[0] = tick;
    for (genvar d = 0; d < 4; d++) begin : g_bcd
        wire asfb_digit_t dig = srv_acc_ff[d*4 +: 4];
        wire logic nine = dig == 4'h9;
        assign bcd_inc[d*4 +: 4] = !carry[d] ? dig :
                                   nine ? 4'h0 : dig + 4'h1;
        assign carry[d+1] = carry[d] & nine;
    end
    // Saturate at 9999 instead of wrapping to a small time
    wire asfb_word_t srv_sum = carry[4] ? srv_acc_ff : bcd_inc;
    // A tick landing on the refresh edge still counts for the ending scan
    assign nxt_srv_acc = scan_en ? `ASFB_RST_WORD : srv_sum;

    // Events for the sticky status
    logic [`ASFB_IRQ_W-1:0] ev;
    assign ev[`ASFB_IRQ_COMM_ERR] = scan_en & comm_err & ~err_bit_ff;
    assign ev[`ASFB_IRQ_NET_ERR] = net_done & net_fail;
    assign ev[`ASFB_IRQ_RESTART] = wr_rst & restart_bit_ff &
                                   ~wb_dat_i[`ASFB_B_RESTART];
    assign ev[`ASFB_IRQ_SLOT] = scan_en & (ibd_src != `ASFB_RST_WORD) &
                                (ibd_ff == `ASFB_RST_WORD);
    assign ev[`ASFB_IRQ_PWR] = pwr_restored;
    wire logic [`ASFB_IRQ_W-1:0] clr = wr_icl ?
        wb_dat_i[`ASFB_IRQ_W-1:0] : '0;

    // Read view; unused positions are zero
    wire asfb_word_t w_err = 16'(err_bit_ff) << `ASFB_B_COMM_ERR;
    wire asfb_word_t w_rst = 16'(restart_bit_ff) << `ASFB_B_RESTART;
    wire asfb_word_t w_net = (16'(conn_ff) << `ASFB_B_CONN) |
                             (16'(net_en_ff) << `ASFB_B_NET_EN) |
                             (16'(net_err_ff) << `ASFB_B_NET_ERR) |
                             16'(net_code_ff);
    // Words 05 and 06 belong to the board logic and read zero here
    wire asfb_word_t rd_mux =
        (idx == `ASFB_IDX_ERR) ? w_err :
        (idx == `ASFB_IDX_RST) ? w_rst :
        (idx == `ASFB_IDX_NET) ? w_net :
        (idx == `ASFB_IDX_SRV) ? srv_word_ff :
        (idx == `ASFB_IDX_IBD) ? ibd_ff :
        (idx == `ASFB_IDX_IST) ? 16'(ist_ff) :
        (idx == `ASFB_IDX_IEN) ? 16'(ien_ff) :
        (idx == `ASFB_IDX_PWR) ? pwr_cnt_ff :
        `ASFB_RST_WORD;

    always_comb begin
        case (bus_ff)
            ASFB_BUS_IDLE: nxt_bus = req ? ASFB_BUS_ACK : ASFB_BUS_IDLE;
            ASFB_BUS_ACK: nxt_bus = ASFB_BUS_IDLE;
            default: nxt_bus = ASFB_BUS_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            bus_ff <= ASFB_BUS_IDLE;
            rd_ff <= `ASFB_RST_WORD;
            hold_sel_ff <= 1'b0;
        end else begin
            bus_ff <= nxt_bus;
            if (take) begin
                rd_ff <= rd_mux;
                hold_sel_ff <= hold_hit;
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            scan_cnt_ff <= '0;
            tick_cnt_ff <= '0;
        end else begin
            scan_cnt_ff <= scan_en ? '0 : scan_cnt_ff + 32'h1;
            tick_cnt_ff <= (scan_en || tick || !comm_busy) ? '0 :
                           tick_cnt_ff + 32'h1;
        end
    end

    // Scan refresh of the shared words
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            err_bit_ff <= 1'b0;
            net_code_ff <= '0;
            net_err_ff <= 1'b0;
            net_en_ff <= 1'b0;
            conn_ff <= 1'b0;
            srv_word_ff <= `ASFB_RST_WORD;
            ibd_ff <= `ASFB_RST_WORD;
        end else if (scan_en) begin
            err_bit_ff <= comm_err;
            net_code_ff <= code_src;
            net_err_ff <= err_src;
            net_en_ff <= net_ready;
            conn_ff <= comm_mounted;
            srv_word_ff <= srv_sum;
            ibd_ff <= ibd_src;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pend_code_ff <= '0;
            pend_err_ff <= 1'b0;
            srv_acc_ff <= `ASFB_RST_WORD;
        end else begin
            if (net_done) begin
                pend_code_ff <= net_code;
                pend_err_ff <= net_fail;
            end
            srv_acc_ff <= nxt_srv_acc;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            restart_bit_ff <= 1'b0;
            restart_pulse_ff <= 1'b0;
            pwr_cnt_ff <= `ASFB_RST_WORD;
        end else begin
            if (wr_rst) begin
                restart_bit_ff <= wb_dat_i[`ASFB_B_RESTART];
            end
            restart_pulse_ff <= ev[`ASFB_IRQ_RESTART];
            if (pwr_restored) begin
                pwr_cnt_ff <= pwr_cnt_ff + 16'h1;
            end
        end
    end

    // Set beats a clear landing in the same cycle
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ist_ff <= '0;
            ien_ff <= '0;
        end else begin
            ist_ff <= (ist_ff & ~clr) | ev;
            if (wr_ien) begin
                ien_ff <= wb_dat_i[`ASFB_IRQ_W-1:0];
            end
        end
    end

    asfb_hold_mem #(
        .WORDS(HOLD_WORDS)
    ) i_asfb_hold_mem (
        .clock(clock),
        .nrst(nrst),
        .we(wr_go & hold_hit),
        .be(wb_sel_i[1:0]),
        .addr(hold_off[HAW-1:0]),
        .wdata(wdat),
        .rdata(hold_q)
    );

    assign wb_ack_o = bus_ff == ASFB_BUS_ACK;
    assign wb_dat_o = {16'h0000, hold_sel_ff ? hold_q : rd_ff};
    assign comm_restart = restart_pulse_ff;
    assign scan_pulse = scan_en;
    assign irq = |(ist_ff & ien_ff);

    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence s_rst_fall;
        wr_rst && restart_bit_ff && !wb_dat_i[`ASFB_B_RESTART];
    endsequence
    sequence s_pulse_once;
        comm_restart ##1 !comm_restart;
    endsequence

    a_ack_single_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_after_take: assert property (take |=> wb_ack_o)
        else $error("request not answered in the next cycle");
    a_restart_pulse: assert property (
        s_rst_fall |=> s_pulse_once)
        else $error("restart pulse missing after high then low");
    a_no_stray_restart: assert property (
        !restart_bit_ff |=> !comm_restart)
        else $error("restart without prior high bit");
    a_err_scan_hold: assert property (
        !scan_en |=> $stable(err_bit_ff) && $stable(ibd_ff))
        else $error("flag changed outside the scan refresh");
    a_err_follows: assert property (
        scan_en |=> err_bit_ff == $past(comm_err))
        else $error("unit error flag not refreshed");
    a_net_code_load: assert property (
        scan_en && net_done |=> net_code_ff == $past(net_code))
        else $error("completion code not loaded");
    a_net_err_set: assert property (
        scan_en && net_done && net_fail |=> net_err_ff)
        else $error("network error flag not set");
    a_net_en_flag: assert property (
        scan_en |=> net_en_ff == $past(net_ready))
        else $error("enabled flag does not follow readiness");
    a_conn_flag: assert property (
        scan_en |=> conn_ff == $past(comm_mounted))
        else $error("connected flag does not follow mounting");
    a_srv_capture: assert property (
        scan_en |=> srv_word_ff == $past(srv_sum) &&
                    srv_acc_ff == `ASFB_RST_WORD)
        else $error("servicing time not captured and cleared");
    a_slot1_hw: assert property (
        scan_en && s1_hw_fault |=> ibd_ff[7:0] == `ASFB_CODE_HW)
        else $error("slot 1 hardware code wrong");
    a_slot2_setup: assert property (
        scan_en && !s2_hw_fault && s2_setup_fault
        |=> ibd_ff[15:8] == `ASFB_CODE_SETUP)
        else $error("slot 2 setup code wrong");
    a_pwr_only: assert property (
        !pwr_restored |=> $stable(pwr_cnt_ff))
        else $error("power-off counter moved without outage");
    a_unused_zero: assert property (
        wb_ack_o && !wb_we_i && idx == `ASFB_IDX_ERR
        |-> wb_dat_o[10:0] == 11'h000 && wb_dat_o[31:12] == 20'h00000)
        else $error("unused bits of word 00 not zero");
endmodule
`default_nettype wire

// ==== shared/asfb_map.svh ====
// Offsets, field positions, codes and timing of the auxiliary flag bank
// Notes on behaviour
// - Holding area bits survive power cycles and run/stop; usable as work bits.
// - Auxiliary words refresh once per scan; power-off counter only on outages.
// - Words 05 and 06 are board specific and not part of this bank.
// - Word 00 bit 11 shows a communications unit error.
// - Program writes restart bit high then low; unit then restarts.
// - Word 02 bits 00-07 hold last network instruction completion code.
// - Word 02 bit 08 set when a network instruction ends in error.
// - Word 02 bit 09 high while a network instruction may be issued.
// - Word 02 bit 15 set while a communications unit is mounted.
// - Word 03 holds last scan servicing time, 4-digit BCD, 0.1 ms units.
// - Word 04 low byte: slot 1 code 00 ok, 01/02 hardware, 04 serial.
// - Word 04 high byte: slot 2 code 00, 01/02, 03 setup, 04 stop.
`ifndef ASFB_MAP_SVH
`define ASFB_MAP_SVH

// Word indices; byte address is four times the index
`define ASFB_IDX_ERR 6'h00
`define ASFB_IDX_RST 6'h01
`define ASFB_IDX_NET 6'h02
`define ASFB_IDX_SRV 6'h03
`define ASFB_IDX_IBD 6'h04
`define ASFB_IDX_IST 6'h08
`define ASFB_IDX_IEN 6'h09
`define ASFB_IDX_ICL 6'h0A
`define ASFB_IDX_PWR 6'h17
`define ASFB_IDX_HOLD 6'h20

`define ASFB_B_COMM_ERR 11
`define ASFB_B_RESTART 11
`define ASFB_B_NET_ERR 8
`define ASFB_B_NET_EN 9
`define ASFB_B_CONN 15

`define ASFB_CODE_OK 8'h00
`define ASFB_CODE_HW 8'h01
`define ASFB_CODE_SETUP 8'h03
`define ASFB_CODE_SERIAL 8'h04
`define ASFB_CODE_STOP 8'h04

`define ASFB_IRQ_COMM_ERR 0
`define ASFB_IRQ_NET_ERR 1
`define ASFB_IRQ_RESTART 2
`define ASFB_IRQ_SLOT 3
`define ASFB_IRQ_PWR 4
`define ASFB_IRQ_W 5

`define ASFB_RST_WORD 16'h0000
`define ASFB_CLK_NS 20
`define ASFB_TICK_NS 100000
`define ASFB_SCAN_NS 1000000

`endif

// ==== shared/asfb_pkg.sv ====
// Types shared by the auxiliary flag bank
package asfb_pkg;
    typedef logic [15:0] asfb_word_t;
    typedef logic [3:0] asfb_digit_t;
    typedef enum logic {ASFB_BUS_IDLE, ASFB_BUS_ACK} asfb_bus_t;
endpackage
